/* File: rtl/ermc_ctrl.v */
// Reduced-trip maintenance mode control with APB register access
//
// Our own choices: the placing of the registers and the APB slave port.
`include "ermc_consts.vh"

module ermc_ctrl #(
  parameter TICK_CYCLES = `ERMC_CLK_HZ,
  parameter DROP_CYCLES = `ERMC_DROP_TIME_S * `ERMC_CLK_HZ,
  parameter LIMIT_SECONDS = `ERMC_ENGAGED_LIMIT_H * `ERMC_SEC_PER_H
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_cradle_connected_contact,
  input wire i_cradle_disconnected_contact,
  input wire i_cradle_test_contact,
  input wire i_disengage_request_input,
  input wire i_engage_request_input,
  input wire i_dial_change,
  input wire i_alarm_reset_manual,
  output reg o_mode_engaged_output,
  output reg o_out1,
  output reg o_out2
);

  // Times cut to counter width on purpose; the widths cover the default times
  localparam integer DROP_LAST_I = DROP_CYCLES - 1;
  localparam integer SEC_LIMIT_I = LIMIT_SECONDS;
  localparam [`ERMC_DROP_W-1:0] DROP_LAST = DROP_LAST_I[`ERMC_DROP_W-1:0];
  localparam [`ERMC_SEC_W-1:0] SEC_LIMIT = SEC_LIMIT_I[`ERMC_SEC_W-1:0];

  // Software-visible state
  reg [`ERMC_CTRL_W-1:0] ctrl;
  reg [`ERMC_THR_W-1:0] passcode;
  reg [`ERMC_THR_W-1:0] normal_thr;
  reg [`ERMC_THR_W-1:0] reduced_thr;
  reg [`ERMC_THR_W-1:0] rated;

  // Mode and alarm state
  reg selected;
  reg disc_alarm;
  reg disc_engaged;
  reg incons_alarm;
  reg long_alarm;
  reg drop_active;

  // Timing counters, sized for the default times
  reg [`ERMC_DROP_W-1:0] drop_cnt;
  reg [`ERMC_SEC_W-1:0] sec_cnt;

  // Registered cradle contacts
  reg cradle_conn;
  reg cradle_disc;
  reg cradle_test;

  wire sec_tick;

  // Bus decode
  wire setup = i_psel && !i_penable;
  wire access = i_psel && i_penable && o_pready;
  wire wr = access && i_pwrite;

  // Offsets that answer without a slave error; the rest read zero and ignore writes
  wire mapped = (i_paddr == `ERMC_OFS_CTRL) || (i_paddr == `ERMC_OFS_CMD) ||
    (i_paddr == `ERMC_OFS_PASSCODE) || (i_paddr == `ERMC_OFS_NORMAL_THR) ||
    (i_paddr == `ERMC_OFS_REDUCED_THR) || (i_paddr == `ERMC_OFS_RATED) ||
    (i_paddr == `ERMC_OFS_STATUS) || (i_paddr == `ERMC_OFS_ALARM_CODE);

  // Selector decode
  wire eng_in = i_engage_request_input;
  wire dis_in = i_disengage_request_input;

  // Equal levels are the only discrepancy; each valid state names one direction
  wire disc_now = (eng_in == dis_in);
  wire eng_req = eng_in && !dis_in;
  wire dis_req = dis_in && !eng_in;

  // Order permission: passcode must be open; the comm module overrides the permit flag
  wire code_open = (passcode == `ERMC_PASSCODE_OPEN);

  // Permit flag matters only without a communication module
  wire permit = ctrl[`ERMC_CTRL_PERMIT];
  wire comm = ctrl[`ERMC_CTRL_COMM_PRESENT];
  wire orders_ok = code_open && (comm || permit);

  // A latched discrepancy blocks only the direction it was raised against
  wire eng_ok = orders_ok && !(disc_alarm && !disc_engaged);
  wire dis_ok = orders_ok && !(disc_alarm && disc_engaged);

  // Alarm reset from software or the manual input
  wire cmd_clear = wr && (i_paddr == `ERMC_OFS_CMD) &&
    i_pwdata[`ERMC_CMD_ALARM_RESET];
  wire alarm_clear = cmd_clear || i_alarm_reset_manual;

  // Thresholds in an order that defeats the mode
  wire thr_inverted = (normal_thr < reduced_thr);

  // Effective mode seen by the trip unit and the pilot output
  wire next_engaged = selected && !thr_inverted && !drop_active;

  // Highest-priority active alarm code
  reg [`ERMC_THR_W-1:0] alarm_code;
  always @* begin
    if (long_alarm) begin
      alarm_code = `ERMC_CODE_LONG;
    end else if (incons_alarm) begin
      alarm_code = `ERMC_CODE_INCONS;
    end else if (disc_alarm) begin
      alarm_code = `ERMC_CODE_DISC;
    end else begin
      alarm_code = `ERMC_CODE_NONE;
    end
  end

  // Status word
  wire [31:0] status_word = {21'h000000,
    cradle_test, cradle_disc, cradle_conn,
    1'b0,
    disc_engaged, drop_active,
    long_alarm, incons_alarm, disc_alarm,
    selected, o_mode_engaged_output};

  // Read mux, sampled in the setup cycle
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (i_paddr)
      `ERMC_OFS_CTRL: next_rdata = {28'h0000000, ctrl};
      `ERMC_OFS_PASSCODE: next_rdata = {16'h0000, passcode};
      `ERMC_OFS_NORMAL_THR: next_rdata = {16'h0000, normal_thr};
      `ERMC_OFS_REDUCED_THR: next_rdata = {16'h0000, reduced_thr};
      `ERMC_OFS_RATED: next_rdata = {16'h0000, rated};
      `ERMC_OFS_STATUS: next_rdata = status_word;
      `ERMC_OFS_ALARM_CODE: next_rdata = {16'h0000, alarm_code};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // APB answer: one wait-free access cycle, all outputs registered
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
      o_pready <= 1'b1;
      o_pslverr <= !mapped;
    end else begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // Register writes take effect at the access edge only
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl <= {`ERMC_CTRL_W{1'b0}};
      passcode <= `ERMC_PASSCODE_RST;
      normal_thr <= `ERMC_NORMAL_RST;
      reduced_thr <= `ERMC_REDUCED_RST;
      rated <= `ERMC_RATED_RST;
    end else if (wr) begin
      case (i_paddr)
        `ERMC_OFS_CTRL: ctrl <= i_pwdata[`ERMC_CTRL_W-1:0];
        `ERMC_OFS_PASSCODE: passcode <= i_pwdata[`ERMC_THR_W-1:0];
        `ERMC_OFS_NORMAL_THR: normal_thr <= i_pwdata[`ERMC_THR_W-1:0];
        `ERMC_OFS_REDUCED_THR: reduced_thr <= i_pwdata[`ERMC_THR_W-1:0];
        `ERMC_OFS_RATED: rated <= i_pwdata[`ERMC_THR_W-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Discrepancy alarm: sticky, and a present discrepancy beats a clear
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      disc_alarm <= 1'b0;
      disc_engaged <= 1'b0;
    end else begin
      if (disc_now) begin
        disc_alarm <= 1'b1;
      end else if (alarm_clear) begin
        disc_alarm <= 1'b0;
      end
      // Remember which way the mode stood when the alarm first rose
      if (disc_now && !disc_alarm) begin
        disc_engaged <= selected;
      end
    end
  end

  // Selected mode follows valid selector states when orders are allowed
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      selected <= 1'b0;
    end else if (eng_req && eng_ok) begin
      selected <= 1'b1;
    end else if (dis_req && dis_ok) begin
      selected <= 1'b0;
    end
  end

  // Dial change drop: counted in cycles so the 5 s is exact, a new change restarts it
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      drop_active <= 1'b0;
      drop_cnt <= {`ERMC_DROP_W{1'b0}};
    end else if (!selected) begin
      drop_active <= 1'b0;
      drop_cnt <= {`ERMC_DROP_W{1'b0}};
    end else if (i_dial_change) begin
      drop_active <= 1'b1;
      drop_cnt <= {`ERMC_DROP_W{1'b0}};
    end else if (drop_active) begin
      if (drop_cnt == DROP_LAST) begin
        drop_active <= 1'b0;
        drop_cnt <= {`ERMC_DROP_W{1'b0}};
      end else begin
        drop_cnt <= drop_cnt + 1'b1;
      end
    end
  end

  // Seconds base, restarted while not selected so the count starts clean
  ermc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_restart(!selected),
    .o_tick(sec_tick)
  );

  // Engaged time in seconds; saturates so the alarm holds until disengaged
  always @(posedge i_ref_clk) begin
    if (i_reset || !selected) begin
      sec_cnt <= {`ERMC_SEC_W{1'b0}};
    end else if (sec_tick && (sec_cnt != SEC_LIMIT)) begin
      sec_cnt <= sec_cnt + 1'b1;
    end
  end

  // Auto-clearing alarms follow their condition directly
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      long_alarm <= 1'b0;
      incons_alarm <= 1'b0;
    end else begin
      long_alarm <= selected && (sec_cnt == SEC_LIMIT);
      incons_alarm <= selected && (reduced_thr > normal_thr);
    end
  end

  // Contacts are synchronous already; one stage keeps status and outputs aligned
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      cradle_conn <= 1'b0;
      cradle_disc <= 1'b0;
      cradle_test <= 1'b0;
    end else begin
      cradle_conn <= i_cradle_connected_contact;
      cradle_disc <= i_cradle_disconnected_contact;
      cradle_test <= i_cradle_test_contact;
    end
  end

  // Pin outputs, all from flops
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_mode_engaged_output <= 1'b0;
      o_out1 <= 1'b0;
      o_out2 <= 1'b0;
    end else begin
      o_mode_engaged_output <= next_engaged;
      o_out1 <= ctrl[`ERMC_CTRL_OUT1_CRADLE] && cradle_conn;
      o_out2 <= ctrl[`ERMC_CTRL_OUT2_CRADLE] && cradle_disc;
    end
  end

endmodule // ermc_ctrl

/* File: rtl/ermc_tick.v */
// One-pulse-per-period divider with phase restart
`include "ermc_consts.vh"

module ermc_tick #(
  parameter TICK_CYCLES = `ERMC_CLK_HZ
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_restart,
  output reg o_tick
);

  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [`ERMC_TICK_W-1:0] TICK_LAST = TICK_LAST_I[`ERMC_TICK_W-1:0];

  reg [`ERMC_TICK_W-1:0] count;

  // Restart aligns the first tick to a full period after the event
  always @(posedge i_ref_clk) begin
    if (i_reset || i_restart) begin
      count <= {`ERMC_TICK_W{1'b0}};
      o_tick <= 1'b0;
    end else if (count == TICK_LAST) begin
      count <= {`ERMC_TICK_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule // ermc_tick

/* File: shared/ermc_consts.vh */
// Constants for the reduced-trip mode control block: map, fields, resets, times
`ifndef ERMC_CONSTS_VH
`define ERMC_CONSTS_VH

// Clock rate and documented times, each in its own unit
`define ERMC_CLK_HZ 100000000
`define ERMC_DROP_TIME_S 5
`define ERMC_ENGAGED_LIMIT_H 24
`define ERMC_SEC_PER_H 3600

// Counter widths sized for the default times
`define ERMC_DROP_W 29
`define ERMC_TICK_W 27
`define ERMC_SEC_W 17

// Register byte offsets
`define ERMC_OFS_CTRL 8'h00
`define ERMC_OFS_CMD 8'h04
`define ERMC_OFS_PASSCODE 8'h08
`define ERMC_OFS_NORMAL_THR 8'h0c
`define ERMC_OFS_REDUCED_THR 8'h10
`define ERMC_OFS_RATED 8'h14
`define ERMC_OFS_STATUS 8'h18
`define ERMC_OFS_ALARM_CODE 8'h1c

// Control register fields
`define ERMC_CTRL_PERMIT 0
`define ERMC_CTRL_COMM_PRESENT 1
`define ERMC_CTRL_OUT1_CRADLE 2
`define ERMC_CTRL_OUT2_CRADLE 3
`define ERMC_CTRL_W 4

// Command register fields
`define ERMC_CMD_ALARM_RESET 0

// Status register fields
`define ERMC_ST_ENGAGED 0
`define ERMC_ST_SELECTED 1
`define ERMC_ST_DISC_ALARM 2
`define ERMC_ST_INCONS_ALARM 3
`define ERMC_ST_LONG_ALARM 4
`define ERMC_ST_DROP 5
`define ERMC_ST_DISC_ENGAGED 6
`define ERMC_ST_CONNECTED 8
`define ERMC_ST_DISCONNECTED 9
`define ERMC_ST_TEST 10

// Reset values
`define ERMC_THR_W 16
`define ERMC_PASSCODE_RST 16'h0000
`define ERMC_PASSCODE_OPEN 16'h0000
`define ERMC_RATED_RST 16'h0064
`define ERMC_REDUCED_RST (`ERMC_RATED_RST << 1)
`define ERMC_NORMAL_RST 16'h0320

// Alarm codes
`define ERMC_CODE_NONE 16'h0000
`define ERMC_CODE_DISC 16'h0c00
`define ERMC_CODE_INCONS 16'h0c01
`define ERMC_CODE_LONG 16'h0c02

`endif

/* File: tb/ermc_ctrl_bench.sv */
// Self-checking bench for the reduced-trip mode control block
module ermc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_dial_change, i_alarm_reset_manual = 0, dial = 0, e;
  logic [7:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic o_pready, o_pslverr, o_mode_engaged_output, o_out1, o_out2;
  logic i_cradle_connected_contact, i_cradle_disconnected_contact, i_cradle_test_contact;
  logic i_disengage_request_input, i_engage_request_input;
  logic [1:0] pos = 2'h2;
  logic [2:0] crd = 3'h0;
  int err_count = 0, tests_run = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  ermc_sel_model mdl (.i_ref_clk(i_ref_clk), .i_pos(pos), .i_dial_req(dial), .i_cradle(crd),
    .o_dis(i_disengage_request_input), .o_eng(i_engage_request_input), .o_dial(i_dial_change),
    .o_cradle({i_cradle_test_contact, i_cradle_disconnected_contact,
    i_cradle_connected_contact}));
  // Short counts: 1 s = 10 cycles, drop 50 cycles, long alarm after 3 s
  ermc_ctrl #(.TICK_CYCLES(10), .DROP_CYCLES(50), .LIMIT_SECONDS(3)) uut (.*);
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Held until pready is sampled; bounded wait guards a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_ref_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    rd = o_prdata;
    e = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    if (k >= 20) begin
      err_count++;
      end_sim();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(rd, x);
  endtask
  task sel(input logic [1:0] p);
    @(posedge i_ref_clk);
    pos <= p;
    cyc(5);
  endtask
  task t_regs;
    rdc(8'h10, 32'h00c8);
    chk(e, 0);
    rdc(8'h0c, 32'h0320);
    apb(0, 8'h40, 32'h0);
    chk(e, 1);
    $display("register defaults done");
  endtask
  task t_perm;
    sel(2'h1);
    chk(o_mode_engaged_output, 0);
    wr(8'h00, 32'h2);
    cyc(4);
    chk(o_mode_engaged_output, 1);
    sel(2'h2);
    chk(o_mode_engaged_output, 0);
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h1);
    sel(2'h1);
    chk(o_mode_engaged_output, 0);
    wr(8'h08, 32'h0);
    cyc(4);
    chk(o_mode_engaged_output, 1);
    rdc(8'h1c, 32'h0);
    cyc(45);
    rdc(8'h1c, 32'h0c02);
    sel(2'h2);
    rdc(8'h1c, 32'h0);
    $display("permission and long alarm done");
  endtask
  task t_disc;
    sel(2'h0);
    rdc(8'h1c, 32'h0c00);
    // Clear while both inputs are still low: the alarm must stay
    wr(8'h04, 32'h1);
    rdc(8'h1c, 32'h0c00);
    sel(2'h1);
    rdc(8'h18, 32'h4);
    chk(o_mode_engaged_output, 0);
    @(posedge i_ref_clk) i_alarm_reset_manual <= 1;
    @(posedge i_ref_clk) i_alarm_reset_manual <= 0;
    cyc(4);
    chk(o_mode_engaged_output, 1);
    sel(2'h3);
    sel(2'h2);
    chk(o_mode_engaged_output, 1);
    wr(8'h04, 32'h1);
    cyc(4);
    chk(o_mode_engaged_output, 0);
    $display("discrepancy done");
  endtask
  task t_dial;
    sel(2'h1);
    @(posedge i_ref_clk) dial <= 1;
    @(posedge i_ref_clk) dial <= 0;
    cyc(43);
    chk(o_mode_engaged_output, 0);
    cyc(15);
    chk(o_mode_engaged_output, 1);
    sel(2'h2);
    sel(2'h1);
    wr(8'h10, 32'h0400);
    cyc(2);
    chk(o_mode_engaged_output, 0);
    rdc(8'h1c, 32'h0c01);
    rdc(8'h10, 32'h0400);
    wr(8'h10, 32'h00c8);
    cyc(3);
    chk(o_mode_engaged_output, 1);
    sel(2'h2);
    $display("dial and thresholds done");
  endtask
  // Contact to output: model edge, contact flop, output flop
  task t_crd;
    wr(8'h00, 32'hd);
    crd <= 3'h5;
    cyc(4);
    chk(o_out1, 1);
    chk(o_out2, 0);
    // Bit 6 still records the last discrepancy, raised while engaged
    rdc(8'h18, 32'h540);
    crd <= 3'h2;
    cyc(4);
    chk(o_out1, 0);
    chk(o_out2, 1);
    wr(8'h00, 32'h1);
    cyc(2);
    chk(o_out2, 0);
    $display("cradle done");
  endtask
  // Reset in mid-run while engaged: mode output off, registers back to defaults
  task t_rst;
    sel(2'h1);
    chk(o_mode_engaged_output, 1);
    wr(8'h10, 32'h0100);
    @(posedge i_ref_clk) i_reset <= 1;
    cyc(3);
    i_reset <= 0;
    cyc(1);
    chk(o_mode_engaged_output, 0);
    rdc(8'h00, 32'h0);
    cyc(4);
    chk(o_mode_engaged_output, 0);
    rdc(8'h10, 32'h00c8);
    $display("mid-run reset done");
  endtask
  initial begin
    cyc(3);
    i_reset <= 0;
    t_regs();
    t_perm();
    t_disc();
    t_dial();
    t_crd();
    t_rst();
    end_sim();
  end
endmodule // ermc_ctrl_bench

/* File: tb/ermc_ctrl_chk.sv */
// Port-level assertions for the reduced-trip mode control block
module ermc_chk (
  input logic i_ref_clk,
  input logic i_reset,
  input logic i_psel,
  input logic i_penable,
  input logic [7:0] i_paddr,
  input logic [31:0] o_prdata,
  input logic o_pready,
  input logic o_pslverr,
  input logic i_cradle_connected_contact,
  input logic i_cradle_disconnected_contact,
  input logic i_dial_change,
  input logic o_mode_engaged_output,
  input logic o_out1,
  input logic o_out2
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Zero wait states: answer right after setup, gone one cycle later
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  unmapped_error_a: assert property (o_pready && i_paddr > 8'h1c |-> o_pslverr)
    else $error("no slave error on unmapped address");
  rdata_idle_zero_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  // Dial change while engaged must drop the mode two edges later and keep it dropped for 8 cycles
  dial_drop_a: assert property (o_mode_engaged_output && i_dial_change |->
    ##2 !o_mode_engaged_output [*8])
    else $error("mode not dropped after dial change");
  // First edge after any release of reset: every pin output still off
  reset_output_off_a: assert property ($fell(i_reset) |->
    !o_mode_engaged_output && !o_out1 && !o_out2 && !o_pready)
    else $error("output on just after reset");
  // Contact reaches the output through two flops
  out1_cradle_a: assert property (o_out1 |-> $past(i_cradle_connected_contact, 2))
    else $error("out1 without connected contact");
  out2_cradle_a: assert property (o_out2 |-> $past(i_cradle_disconnected_contact, 2))
    else $error("out2 without disconnected contact");
  cover property (o_pready && o_pslverr);
  cover property ($rose(o_mode_engaged_output));
  cover property (o_mode_engaged_output && i_dial_change);
endmodule // ermc_chk
bind ermc_ctrl ermc_chk chk (.*);

/* File: tb/ermc_sel_model.sv */
// Selector switch, trip unit dial and cradle contacts seen by the block
module ermc_sel_model (
  input logic i_ref_clk,
  input logic [1:0] i_pos,
  input logic i_dial_req,
  input logic [2:0] i_cradle,
  output logic o_dis,
  output logic o_eng,
  output logic o_dial,
  output logic [2:0] o_cradle
);
  timeunit 1ns;
  timeprecision 1ns;
  // Switch levels lag the request by one edge, like a contact settling
  always @(posedge i_ref_clk) begin
    {o_dis, o_eng} <= i_pos;
    o_dial <= i_dial_req;
    o_cradle <= i_cradle;
  end
endmodule // ermc_sel_model
